// [src/cgw_pkg.sv]
// Constants shared by the code segment write guard.
// Assumes a single 25 MHz clock domain and a 32-bit AXI4-Lite register bus.
package cgw_pkg;
  localparam int          CGW_ADDR_W        = 18;
  localparam int          CGW_PAGE_W        = 9;
  localparam int          CGW_PAGE_LSB      = 9;
  localparam int          CGW_CFG_W         = 17;
  localparam int          CGW_ST_W          = 3;
  localparam int          CGW_RAM_W         = 16;
  localparam logic [8:0]  CGW_LAST_PAGE     = 9'h1ff;
  localparam logic [17:0] CGW_CFG_WORD_BASE = 18'h3fffc;
  localparam logic [15:0] CGW_DBG_RAM_BYTES = 16'h0050;
  // Configuration word field positions.
  localparam int          CGW_B_DIS         = 0;
  localparam int          CGW_B_BSEL        = 1;
  localparam int          CGW_B_LPP         = 2;
  localparam int          CGW_B_PN_LSB      = 3;
  localparam int          CGW_B_GCP         = 12;
  localparam int          CGW_B_GWP         = 13;
  localparam int          CGW_B_DCS_LSB     = 14;
  localparam int          CGW_B_DBG         = 16;
  localparam logic [16:0] CGW_CFG_RST       = 17'h02007;
  // Register byte offsets.
  localparam logic [7:0]  CGW_OFF_CFG       = 8'h00;
  localparam logic [7:0]  CGW_OFF_STATUS    = 8'h04;
  localparam logic [7:0]  CGW_OFF_INT_EN    = 8'h08;
  localparam logic [7:0]  CGW_OFF_INT_CLR   = 8'h0c;
  localparam logic [7:0]  CGW_OFF_LAST_DENY = 8'h10;
  // Status bits.
  localparam int          CGW_ST_PARITY     = 0;
  localparam int          CGW_ST_DENY       = 1;
  localparam int          CGW_ST_LOAD       = 2;
  localparam logic [2:0]  CGW_INT_EN_RST    = 3'h0;
  localparam logic [1:0]  CGW_RESP_OKAY     = 2'h0;
  localparam logic [1:0]  CGW_RESP_SLVERR   = 2'h2;

  typedef enum logic [0:0] {
    CGW_REQ_READ  = 1'b0,
    CGW_REQ_WRITE = 1'b1
  } cgw_req_t;

  function automatic logic [8:0] cgw_page_of(input logic [17:0] addr);
    return addr[17:9];
  endfunction
endpackage

// [src/cgw_cfg_shadow.sv]
// Configuration register with a complemented shadow copy and a compare.
// Assumes the load strobe comes from the flash configuration word fetch.
`timescale 1ns/1ps
`default_nettype none
module cgw_cfg_shadow
  import cgw_pkg::*;
(
  // Clock and reset.
  input  wire logic                 ref_clk,
  input  wire logic                 sys_rst,
  // Load from flash and cell disturbance.
  input  wire logic                 loadValid,
  input  wire logic [CGW_CFG_W-1:0] loadWord,
  input  wire logic [CGW_CFG_W-1:0] upsetMask,
  // Result.
  output logic      [CGW_CFG_W-1:0] cfgOut,
  output logic                      mismatch
);
  logic [CGW_CFG_W-1:0] cfg_ff;
  logic [CGW_CFG_W-1:0] shadow_ff;
  logic [CGW_CFG_W-1:0] nxt_cfg;
  logic [CGW_CFG_W-1:0] nxt_shadow;

  // A load writes both copies; a disturbance hits only the live copy.
  always_comb begin
    nxt_cfg    = cfg_ff ^ upsetMask;
    nxt_shadow = shadow_ff;
    if (loadValid) begin
      nxt_cfg    = loadWord;
      nxt_shadow = ~loadWord;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_ff    <= CGW_CFG_RST;
      shadow_ff <= ~CGW_CFG_RST;
    end else begin
      cfg_ff    <= nxt_cfg;
      shadow_ff <= nxt_shadow;
    end
  end

  assign cfgOut   = cfg_ff;
  assign mismatch = (cfg_ff != ~shadow_ff);
endmodule
`default_nettype wire

// [src/cgw_seg_decode.sv]
// Combinational decode of whether a program memory access is blocked.
// Assumes the configuration fields are stable registered values.
`timescale 1ns/1ps
`default_nettype none
module cgw_seg_decode
  import cgw_pkg::*;
(
  // Configuration fields.
  input  wire logic                  segDisable,
  input  wire logic                  boundarySel,
  input  wire logic                  lastPageProt,
  input  wire logic [CGW_PAGE_W-1:0] pageNumber,
  input  wire logic                  genCodeProt,
  input  wire logic                  genWriteProt,
  // Access.
  input  wire logic [CGW_ADDR_W-1:0] addr,
  input  wire cgw_req_t              kind,
  input  wire logic                  external,
  // Decision.
  output logic                       blocked
);
  logic [CGW_PAGE_W-1:0] page;
  logic                  isCfg;
  logic                  segHit;
  logic                  genHit;

  always_comb begin
    page  = cgw_page_of(addr);
    isCfg = (addr >= CGW_CFG_WORD_BASE);
    case ({segDisable, boundarySel, lastPageProt})
      3'b100, 3'b110: segHit = (page == CGW_LAST_PAGE);
      3'b101, 3'b111: segHit = 1'b0;
      3'b010, 3'b011: segHit = (page >= pageNumber);
      3'b000:         segHit = (page <= pageNumber);
      3'b001:         segHit = (page >= pageNumber) && !isCfg;
      default:        segHit = 1'b1;
    endcase
    // External access of any kind is closed by general code protect,
    // which also covers the configuration words.
    genHit = (external && genCodeProt) ||
             (!external && !genWriteProt);
    if (kind == CGW_REQ_WRITE) begin
      blocked = genHit || segHit;
    end else begin
      blocked = external && genCodeProt;
    end
  end
endmodule
`default_nettype wire

// [src/cgw_guard.sv]
// Top of the code segment write guard: flash operation interlock,
// configuration parity check, debug reservations and AXI4-Lite registers.
// Assumes the flash controller holds a request until it sees an answer.
//
// Local design decisions: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Complemented shadow copy compared continuously
// - Mismatch flags parity error and forces reset
// - Configuration loaded from flash configuration words
// - General code protect also covers configuration words
// - Disable and last-page bits set: general only
// - Disable set, last-page clear: last page blocked
// - Segment on, top boundary: page through end
// - All clear: address zero through selected page
// - Top range without configuration words
// - Nine-bit page field; selected page included
// - Test port also serves serial programming
// - Debug uses the selected clock/data pin pair
// - Debug reserves low 80 RAM bytes, two pins
// - One page step is 512 words
// - Code protect blocks external access only
// - Write protect clear blocks internal writes
// - Segment protection only adds to general
module cgw_guard
  import cgw_pkg::*;
(
  // Clock and reset.
  input  wire logic                  ref_clk,
  input  wire logic                  sys_rst,
  // AXI4-Lite write channels.
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  // AXI4-Lite read channels.
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // Configuration word fetch and disturbance input.
  input  wire logic                  cfgLoadValid,
  input  wire logic [CGW_CFG_W-1:0]  cfgLoadWord,
  input  wire logic [CGW_CFG_W-1:0]  cfgUpsetMask,
  // Flash operation interlock.
  input  wire logic                  opReq,
  input  wire logic [CGW_ADDR_W-1:0] opAddr,
  input  wire cgw_req_t              opKind,
  input  wire logic                  opExternal,
  output logic                       opGrant,
  output logic                       opDeny,
  // Debug resources.
  input  wire logic [CGW_RAM_W-1:0]  ramAccAddr,
  output logic                       dbgRamBlock,
  output logic                       dbgPinReserve,
  output logic [1:0]                 debug_channel_select,
  // System.
  output logic                       devRstReq,
  output logic                       irq
);
  logic [CGW_CFG_W-1:0]  cfg;
  logic                  mismatch;
  logic                  blocked;
  logic                  take;
  logic [CGW_PAGE_W-1:0] pn;

  cgw_cfg_shadow u_shadow (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .loadValid (cfgLoadValid),
    .loadWord  (cfgLoadWord),
    .upsetMask (cfgUpsetMask),
    .cfgOut    (cfg),
    .mismatch  (mismatch)
  );

  assign pn = cfg[CGW_B_PN_LSB +: CGW_PAGE_W];

  cgw_seg_decode u_decode (
    .segDisable   (cfg[CGW_B_DIS]),
    .boundarySel  (cfg[CGW_B_BSEL]),
    .lastPageProt (cfg[CGW_B_LPP]),
    .pageNumber   (pn),
    .genCodeProt  (cfg[CGW_B_GCP]),
    .genWriteProt (cfg[CGW_B_GWP]),
    .addr         (opAddr),
    .kind         (opKind),
    .external     (opExternal),
    .blocked      (blocked)
  );

  // Flash interlock: answer one cycle after the request is taken.
  logic                  grant_ff;
  logic                  deny_ff;
  logic [CGW_ADDR_W-1:0] lastDeny_ff;
  logic                  nxt_grant;
  logic                  nxt_deny;
  logic [CGW_ADDR_W-1:0] nxt_lastDeny;

  // External requests arrive from the test port, which also carries
  // serial programming traffic, and pass through the same check.
  assign take = opReq && !grant_ff && !deny_ff;

  always_comb begin
    nxt_grant    = take && !blocked;
    nxt_deny     = take && blocked;
    nxt_lastDeny = lastDeny_ff;
    if (nxt_deny) begin
      nxt_lastDeny = opAddr;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      grant_ff    <= 1'b0;
      deny_ff     <= 1'b0;
      lastDeny_ff <= '0;
    end else begin
      grant_ff    <= nxt_grant;
      deny_ff     <= nxt_deny;
      lastDeny_ff <= nxt_lastDeny;
    end
  end

  // Debug reservation and reset request.
  logic       dbgRam_ff;
  logic       dbgPin_ff;
  logic [1:0] dcs_ff;
  logic       rstReq_ff;
  logic       nxt_dbgRam;
  logic       nxt_dbgPin;
  logic [1:0] nxt_dcs;
  logic       nxt_rstReq;

  always_comb begin
    nxt_dbgRam = cfg[CGW_B_DBG] && (ramAccAddr < CGW_DBG_RAM_BYTES);
    nxt_dbgPin = cfg[CGW_B_DBG];
    nxt_dcs    = cfg[CGW_B_DCS_LSB +: 2];
    nxt_rstReq = mismatch;
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      dbgRam_ff <= 1'b0;
      dbgPin_ff <= 1'b0;
      dcs_ff    <= 2'h0;
      rstReq_ff <= 1'b0;
    end else begin
      dbgRam_ff <= nxt_dbgRam;
      dbgPin_ff <= nxt_dbgPin;
      dcs_ff    <= nxt_dcs;
      rstReq_ff <= nxt_rstReq;
    end
  end

  // AXI4-Lite write path: address and data are taken in either order.
  logic        awHeld_ff;
  logic [7:0]  awAddr_ff;
  logic        wHeld_ff;
  logic [31:0] wData_ff;
  logic [3:0]  wStrb_ff;
  logic        awready_ff;
  logic        wready_ff;
  logic        bvalid_ff;
  logic [1:0]  bresp_ff;
  logic        nxt_awHeld;
  logic [7:0]  nxt_awAddr;
  logic        nxt_wHeld;
  logic [31:0] nxt_wData;
  logic [3:0]  nxt_wStrb;
  logic        nxt_awready;
  logic        nxt_wready;
  logic        nxt_bvalid;
  logic [1:0]  nxt_bresp;
  logic        doWrite;
  logic [2:0]  intEn_ff;
  logic [2:0]  nxt_intEn;
  logic [2:0]  clrMask;

  always_comb begin
    nxt_awHeld = awHeld_ff;
    nxt_awAddr = awAddr_ff;
    nxt_wHeld  = wHeld_ff;
    nxt_wData  = wData_ff;
    nxt_wStrb  = wStrb_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp  = bresp_ff;
    nxt_intEn  = intEn_ff;
    clrMask    = 3'h0;
    doWrite    = awHeld_ff && wHeld_ff && !bvalid_ff;
    if (s_axi_awvalid && awready_ff) begin
      nxt_awHeld = 1'b1;
      nxt_awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_ff) begin
      nxt_wHeld = 1'b1;
      nxt_wData = s_axi_wdata;
      nxt_wStrb = s_axi_wstrb;
    end
    if (bvalid_ff && s_axi_bready) begin
      nxt_bvalid = 1'b0;
    end
    if (doWrite) begin
      nxt_awHeld = 1'b0;
      nxt_wHeld  = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp  = CGW_RESP_OKAY;
      case (awAddr_ff)
        CGW_OFF_INT_EN: begin
          if (wStrb_ff[0]) begin
            nxt_intEn = wData_ff[CGW_ST_W-1:0];
          end
        end
        CGW_OFF_INT_CLR: begin
          if (wStrb_ff[0]) begin
            clrMask = wData_ff[CGW_ST_W-1:0];
          end
        end
        default: nxt_bresp = CGW_RESP_SLVERR;
      endcase
    end
    nxt_awready = !nxt_awHeld && !nxt_bvalid;
    nxt_wready  = !nxt_wHeld && !nxt_bvalid;
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      awHeld_ff  <= 1'b0;
      awAddr_ff  <= 8'h00;
      wHeld_ff   <= 1'b0;
      wData_ff   <= 32'h0000_0000;
      wStrb_ff   <= 4'h0;
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= CGW_RESP_OKAY;
      intEn_ff   <= CGW_INT_EN_RST;
    end else begin
      awHeld_ff  <= nxt_awHeld;
      awAddr_ff  <= nxt_awAddr;
      wHeld_ff   <= nxt_wHeld;
      wData_ff   <= nxt_wData;
      wStrb_ff   <= nxt_wStrb;
      awready_ff <= nxt_awready;
      wready_ff  <= nxt_wready;
      bvalid_ff  <= nxt_bvalid;
      bresp_ff   <= nxt_bresp;
      intEn_ff   <= nxt_intEn;
    end
  end

  // Sticky status: a new event in the clearing cycle stays set.
  logic [2:0] status_ff;
  logic [2:0] nxt_status;
  logic       irq_ff;
  logic       nxt_irq;
  logic [2:0] events;

  always_comb begin
    events                = 3'h0;
    events[CGW_ST_PARITY] = mismatch;
    events[CGW_ST_DENY]   = nxt_deny;
    events[CGW_ST_LOAD]   = cfgLoadValid;
    nxt_status            = (status_ff & ~clrMask) | events;
    nxt_irq               = |(nxt_status & nxt_intEn);
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      status_ff <= 3'h0;
      irq_ff    <= 1'b0;
    end else begin
      status_ff <= nxt_status;
      irq_ff    <= nxt_irq;
    end
  end

  // AXI4-Lite read path.
  logic        arready_ff;
  logic        rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0]  rresp_ff;
  logic        nxt_arready;
  logic        nxt_rvalid;
  logic [31:0] nxt_rdata;
  logic [1:0]  nxt_rresp;

  always_comb begin
    nxt_rvalid = rvalid_ff;
    nxt_rdata  = rdata_ff;
    nxt_rresp  = rresp_ff;
    if (rvalid_ff && s_axi_rready) begin
      nxt_rvalid = 1'b0;
    end
    if (s_axi_arvalid && arready_ff) begin
      nxt_rvalid = 1'b1;
      nxt_rresp  = CGW_RESP_OKAY;
      nxt_rdata  = 32'h0000_0000;
      case (s_axi_araddr)
        CGW_OFF_CFG:       nxt_rdata[CGW_CFG_W-1:0]  = cfg;
        CGW_OFF_STATUS:    nxt_rdata[CGW_ST_W-1:0]   = status_ff;
        CGW_OFF_INT_EN:    nxt_rdata[CGW_ST_W-1:0]   = intEn_ff;
        CGW_OFF_INT_CLR:   nxt_rdata                 = 32'h0000_0000;
        CGW_OFF_LAST_DENY: nxt_rdata[CGW_ADDR_W-1:0] = lastDeny_ff;
        default:           nxt_rresp                 = CGW_RESP_SLVERR;
      endcase
    end
    nxt_arready = !nxt_rvalid;
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h0000_0000;
      rresp_ff   <= CGW_RESP_OKAY;
    end else begin
      arready_ff <= nxt_arready;
      rvalid_ff  <= nxt_rvalid;
      rdata_ff   <= nxt_rdata;
      rresp_ff   <= nxt_rresp;
    end
  end

  assign s_axi_awready        = awready_ff;
  assign s_axi_wready         = wready_ff;
  assign s_axi_bvalid         = bvalid_ff;
  assign s_axi_bresp          = bresp_ff;
  assign s_axi_arready        = arready_ff;
  assign s_axi_rvalid         = rvalid_ff;
  assign s_axi_rdata          = rdata_ff;
  assign s_axi_rresp          = rresp_ff;
  assign opGrant              = grant_ff;
  assign opDeny               = deny_ff;
  assign dbgRamBlock          = dbgRam_ff;
  assign dbgPinReserve        = dbgPin_ff;
  assign debug_channel_select = dcs_ff;
  assign devRstReq            = rstReq_ff;
  assign irq                  = irq_ff;

  // Checks on the guard's own outputs.
  logic                  wr;
  logic [CGW_PAGE_W-1:0] opPage;
  logic                  genOk;
  assign wr     = take && (opKind == CGW_REQ_WRITE);
  assign opPage = cgw_page_of(opAddr);
  assign genOk  = cfg[CGW_B_GWP] && !(opExternal && cfg[CGW_B_GCP]);

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  property p_parity_reset;
    mismatch |=> devRstReq && status_ff[CGW_ST_PARITY];
  endproperty
  a_parity_reset: assert property (p_parity_reset) else $error("parity reset missed");

  property p_shadow_load;
    cfgLoadValid && (cfgUpsetMask == '0) |=> !mismatch ##1 !devRstReq;
  endproperty
  a_shadow_load: assert property (p_shadow_load) else $error("shadow not loaded");

  property p_blocked_denied;
    take && blocked |=> opDeny && !opGrant ##1 !opDeny;
  endproperty
  a_blocked_denied: assert property (p_blocked_denied) else $error("blocked op not denied");

  property p_no_segment;
    wr && cfg[CGW_B_DIS] && cfg[CGW_B_LPP] && genOk |=> opGrant;
  endproperty
  a_no_segment: assert property (p_no_segment) else $error("unprotected write denied");

  property p_last_page;
    wr && cfg[CGW_B_DIS] && !cfg[CGW_B_LPP] && (opPage == CGW_LAST_PAGE) |=> opDeny;
  endproperty
  a_last_page: assert property (p_last_page) else $error("last page write granted");

  property p_bottom_range;
    wr && (cfg[2:0] == 3'b000) && (opPage <= pn) |=> opDeny;
  endproperty
  a_bottom_range: assert property (p_bottom_range) else $error("bottom segment granted");

  property p_gcp_cfg_words;
    wr && opExternal && cfg[CGW_B_GCP] && (opAddr >= CGW_CFG_WORD_BASE) |=> opDeny;
  endproperty
  a_gcp_cfg_words: assert property (p_gcp_cfg_words) else $error("config words open");

  property p_top_range;
    wr && !cfg[CGW_B_DIS] && cfg[CGW_B_BSEL] && (opPage >= pn) |=> opDeny;
  endproperty
  a_top_range: assert property (p_top_range) else $error("top segment granted");

  property p_cfg_words_open;
    wr && (cfg[2:0] == 3'b100) && (opAddr >= CGW_CFG_WORD_BASE) && genOk |=> opGrant;
  endproperty
  a_cfg_words_open: assert property (p_cfg_words_open) else $error("config words blocked");

  property p_write_protect;
    wr && !opExternal && !cfg[CGW_B_GWP] |=> opDeny;
  endproperty
  a_write_protect: assert property (p_write_protect) else $error("write protect ignored");

  property p_internal_read;
    take && (opKind == CGW_REQ_READ) && !opExternal |=> opGrant;
  endproperty
  a_internal_read: assert property (p_internal_read) else $error("internal read blocked");

  property p_debug_ram;
    cfg[CGW_B_DBG] && (ramAccAddr < CGW_DBG_RAM_BYTES) |=> dbgRamBlock && dbgPinReserve;
  endproperty
  a_debug_ram: assert property (p_debug_ram) else $error("debug RAM not reserved");
endmodule
`default_nettype wire

// [sim/cgw_flash_model.sv]
// Flash write/erase controller and serial programmer stand-in for the guard.
// Assumes the guard answers each held request with one grant or deny pulse.
`timescale 1ns/1ps
`default_nettype none
module cgw_flash_model
  import cgw_pkg::*;
(
  // Clock and reset.
  input  wire logic                  ref_clk,
  input  wire logic                  sys_rst,
  // Command from the bench.
  input  wire logic                  start,
  input  wire logic [CGW_ADDR_W-1:0] addr,
  input  wire cgw_req_t              kind,
  input  wire logic                  ext,
  output logic                       done,
  output logic                       granted,
  // Interlock side.
  output logic                       opReq,
  output logic [CGW_ADDR_W-1:0]      opAddr,
  output cgw_req_t                   opKind,
  output logic                       opExternal,
  input  wire logic                  opGrant,
  input  wire logic                  opDeny
);
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      opReq      <= 1'b0;
      opAddr     <= '0;
      opKind     <= CGW_REQ_READ;
      opExternal <= 1'b0;
      done       <= 1'b0;
      granted    <= 1'b0;
    end else begin
      done <= 1'b0;
      if (opReq && (opGrant || opDeny)) begin
        // Released address lines no longer show the old address.
        opReq   <= 1'b0;
        opAddr  <= ~opAddr;
        done    <= 1'b1;
        granted <= opGrant;
      end else if (start && !opReq) begin
        // External requests stand for the two-wire serial programmer.
        opReq      <= 1'b1;
        opAddr     <= addr;
        opKind     <= kind;
        opExternal <= ext;
      end
    end
  end
endmodule
`default_nettype wire

// [sim/cgw_guard_tb.sv]
// Self-checking bench for the code segment write guard.
// Assumes the flash model in cgw_flash_model and a 25 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module cgw_guard_tb;
  import cgw_pkg::*;
  logic        ref_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata = 32'h0, rdata;
  logic [1:0]  bresp, rresp, dcs;
  logic        cfgLoadValid = 1'b0, start = 1'b0, ext = 1'b0;
  logic        done, granted, opReq, opExternal, opGrant, opDeny;
  logic [16:0] cfgLoadWord = 17'h0, cfgUpsetMask = 17'h0;
  logic [17:0] addr = 18'h0, opAddr;
  cgw_req_t    kind = CGW_REQ_READ, opKind;
  logic [15:0] ramAccAddr = 16'h0;
  logic        dbgRamBlock, dbgPinReserve, devRstReq, irq;
  int          mismatches = 0, compares = 0;
  logic [17:0] addrs [7] = '{18'h0, 18'h021ff, 18'h02000, 18'h01fff, 18'h02200,
                              18'h3fe00, 18'h3fffc};
  localparam logic [8:0] PN = 9'h010;

  initial forever #20 ref_clk = ~ref_clk;

  cgw_guard u_cgw_guard (.ref_clk(ref_clk), .sys_rst(sys_rst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .cfgLoadValid(cfgLoadValid), .cfgLoadWord(cfgLoadWord), .cfgUpsetMask(cfgUpsetMask),
    .opReq(opReq), .opAddr(opAddr), .opKind(opKind), .opExternal(opExternal),
    .opGrant(opGrant), .opDeny(opDeny), .ramAccAddr(ramAccAddr), .dbgRamBlock(dbgRamBlock),
    .dbgPinReserve(dbgPinReserve), .debug_channel_select(dcs), .devRstReq(devRstReq),
    .irq(irq));

  cgw_flash_model u_cgw_flash_model (.ref_clk(ref_clk), .sys_rst(sys_rst), .start(start),
    .addr(addr), .kind(kind), .ext(ext), .done(done), .granted(granted), .opReq(opReq),
    .opAddr(opAddr), .opKind(opKind), .opExternal(opExternal), .opGrant(opGrant),
    .opDeny(opDeny));

  task automatic give_verdict();
    if (mismatches == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic tmo(input int n);
    if (n >= 50) begin
      chk("timeout", 32'h0, 32'h1);
      give_verdict();
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge ref_clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge ref_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) break;
    end
    r = bresp;
    bready <= 1'b0;
    tmo(n);
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge ref_clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge ref_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    tmo(n);
  endtask

  task automatic flash_op(input logic [17:0] a, input cgw_req_t k, input logic e,
                          output logic g);
    int n;
    @(posedge ref_clk);
    addr  <= a;
    kind  <= k;
    ext   <= e;
    start <= 1'b1;
    @(posedge ref_clk);
    start <= 1'b0;
    for (n = 0; n < 50 && !done; n++) @(posedge ref_clk);
    g = granted;
    tmo(n);
  endtask

  task automatic load_cfg(input logic [16:0] w);
    @(posedge ref_clk);
    cfgLoadWord  <= w;
    cfgLoadValid <= 1'b1;
    @(posedge ref_clk);
    cfgLoadValid <= 1'b0;
  endtask

  // Mode m holds disable, boundary select and last page protect, in that order.
  function automatic logic [16:0] mk(input logic [2:0] m, input logic general_code_protect, input logic gwp);
    return {3'b000, gwp, general_code_protect, PN, m[0], m[1], m[2]};
  endfunction

  function automatic logic seg_hit(input logic [2:0] m, input logic [17:0] a);
    logic [8:0] pg;
    pg = a[17:9];
    casez (m)
      3'b1?1: return 1'b0;
      3'b1?0: return pg == 9'h1ff;
      3'b01?: return pg >= PN;
      3'b000: return pg <= PN;
      default: return pg >= PN && a < 18'h3fffc;
    endcase
  endfunction

  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    logic        g;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    axi_rd(CGW_OFF_CFG, d, r);
    chk("cfg_reset", 32'h00002007, d);
    axi_rd(8'h14, d, r);
    chk("unmapped_resp", 32'h2, 32'(r));
    for (int m = 0; m < 8; m++) begin
      load_cfg(mk(3'(m), 1'b0, 1'b1));
      for (int i = 0; i < 7; i++) begin
        flash_op(addrs[i], CGW_REQ_WRITE, 1'b0, g);
        chk("seg_grant", 32'(!seg_hit(3'(m), addrs[i])), 32'(g));
      end
    end
    load_cfg(mk(3'b101, 1'b0, 1'b0));
    flash_op(18'h00100, CGW_REQ_WRITE, 1'b0, g);
    chk("gwp_write", 32'h0, 32'(g));
    flash_op(18'h00100, CGW_REQ_READ, 1'b0, g);
    chk("gwp_read", 32'h1, 32'(g));
    load_cfg(mk(3'b101, 1'b1, 1'b1));
    flash_op(18'h00100, CGW_REQ_WRITE, 1'b0, g);
    chk("gcp_internal", 32'h1, 32'(g));
    flash_op(18'h00000, CGW_REQ_READ, 1'b1, g);
    chk("gcp_ext_read", 32'h0, 32'(g));
    flash_op(18'h3fffc, CGW_REQ_WRITE, 1'b1, g);
    chk("gcp_cfg_word", 32'h0, 32'(g));
    axi_rd(CGW_OFF_CFG, d, r);
    chk("cfg_load", 32'(mk(3'b101, 1'b1, 1'b1)), d);
    axi_rd(CGW_OFF_LAST_DENY, d, r);
    chk("last_deny", 32'h0003fffc, d);
    chk("irq_masked", 32'h0, 32'(irq));
    axi_wr(CGW_OFF_INT_EN, 32'h2, r);
    chk("en_resp", 32'h0, 32'(r));
    @(posedge ref_clk);
    chk("irq_on", 32'h1, 32'(irq));
    axi_wr(CGW_OFF_INT_CLR, 32'h2, r);
    @(posedge ref_clk);
    chk("irq_off", 32'h0, 32'(irq));
    axi_rd(CGW_OFF_INT_EN, d, r);
    chk("int_en", 32'h2, d);
    axi_rd(CGW_OFF_STATUS, d, r);
    chk("status_clr", 32'h4, d);
    axi_wr(CGW_OFF_CFG, 32'h0, r);
    chk("ro_write", 32'h2, 32'(r));
    cfgUpsetMask <= 17'h00010;
    @(posedge ref_clk);
    cfgUpsetMask <= 17'h00000;
    for (int n = 0; n < 5 && !devRstReq; n++) @(posedge ref_clk);
    chk("parity_reset", 32'h1, 32'(devRstReq));
    axi_rd(CGW_OFF_STATUS, d, r);
    chk("parity_status", 32'h1, 32'(d[0]));
    load_cfg(mk(3'b101, 1'b0, 1'b1) | 17'h18000);
    ramAccAddr <= 16'h004f;
    repeat (2) @(posedge ref_clk);
    chk("parity_clear", 32'h0, 32'(devRstReq));
    chk("ram_low", 32'h1, 32'(dbgRamBlock));
    ramAccAddr <= 16'h0050;
    repeat (2) @(posedge ref_clk);
    chk("ram_80", 32'h0, 32'(dbgRamBlock));
    chk("pins", 32'h1, 32'(dbgPinReserve));
    chk("channel", 32'h2, 32'(dcs));
    give_verdict();
  end
endmodule
`default_nettype wire
